// ### include/strap_defines.vh
/*
 * Register offsets, field positions and timing counts of the transceiver
 * strap and link configuration block.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef STRAP_DEFINES_VH
`define STRAP_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets on the management register port
// ----------------------------------------------------------------------
`define ADDR_BASIC_CTRL       5'h00
`define ADDR_ADVERTISE        5'h04
`define ADDR_SOFT_STRAP_ONE   5'h09
`define ADDR_SOFT_STRAP_TWO   5'h0A
`define ADDR_SOFT_STRAP_THREE 5'h0B
`define ADDR_XCVR_CTRL        5'h19
`define ADDR_SOFT_RESET_CTRL  5'h1F

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_BASIC_ISOLATE     10
`define BIT_BASIC_NEG_EN      12
`define BIT_ADV_10_HALF       5
`define BIT_ADV_10_FULL       6
`define BIT_ADV_100_HALF      7
`define BIT_ADV_100_FULL      8
`define BIT_SS1_CONFIG_DONE   15
`define BIT_SS1_XOVER_EN      14
`define BIT_SS1_NEG_EN        13
`define BIT_SS1_ABIL_HI       12
`define BIT_SS1_ABIL_LO       11
`define BIT_SS1_OVERRIDE      10
`define BIT_XCVR_XOVER_EN     15
`define BIT_XCVR_XOVER_FORCE  14
`define BIT_RST_SOFT_RESET    15
`define BIT_RST_SOFT_RESTART  14

// ----------------------------------------------------------------------
// strap pin positions in the synchroniser vector
// ----------------------------------------------------------------------
`define STRAP_ABIL_LO         0
`define STRAP_ABIL_HI         1
`define STRAP_NEG_EN          2
`define STRAP_ADDR_LO         3
`define STRAP_ADDR_HI         7
`define STRAP_XOVER_EN        8
`define STRAP_SOFT_SEL        9

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RESET_WORD_ZERO       16'h0000
`define RESET_ADV_SELECTOR    16'h0001
`define RESET_INT_PULSE_LEN   4'h4
`define RESET_PHY_ADDR        5'h01

`endif

// ### src/strap_link_config.v
/*
 * Strap latching and link configuration of a 10/100 transceiver: hardware
 * and software straps, advertisement, crossover, isolation, mode resolve.
 * Assumes a management frame engine on the same clock that presents
 * one-cycle register read/write strobes, and strap pins that are
 * asynchronous and stable around hardware reset release.
 * Transmit gating and MAC output enables stay low while isolated or held.
 */
// Overview of operation
// - partner without negotiation: speed from parallel detect, duplex forced half
// - four protocols; resolve to best mode both sides advertise
// - negotiation strap low: ability straps force speed and duplex
// - negotiation strap high: ability straps choose advertised abilities
// - strap abilities loaded into advertisement bits 8 to 5 at reset
// - crossover on by default; strap, soft strap bit 14, control bit 15
// - control bit 14 forces crossover regardless of negotiation or auto
// - automatic crossover keeps working in forced 100 Mb/s
// - both sides automatic: random arbitration picks who crosses
// - basic control bit 10 isolates the MAC data interface
// - isolated: transmit inputs ignored, MAC outputs released
// - isolated: management reads and writes still answered
// - isolated: line keeps idles or pulses, negotiation and link continue
// - five address straps share collision and receive data pins
// - address straps latched at power-up and each hardware reset
// - with no strap parts, latched address defaults to 00001
// - select pin low: start in soft strap mode, held powered down
// - while held down, host programs strap registers through management
// - config done bit: leave power-down, pulse reset, latch soft straps
// - latched soft straps survive soft reset and restart bits
// - three soft strap registers hold virtual strap options
// - crossover strap pulled up by default, pull-down disables
`timescale 1ns/10ps
`include "strap_defines.vh"

module strap_link_config #(
  parameter LFSR_WIDTH = 11
) (
  input  wire        CLOCK_IN,
  input  wire        RESET_N_IN,
  input  wire        NEG_EN_STRAP_IN,
  input  wire        ABIL_HI_STRAP_IN,
  input  wire        ABIL_LO_STRAP_IN,
  input  wire        XOVER_EN_STRAP_IN,
  input  wire [4:0]  ADDR_STRAP_IN,
  input  wire        SOFT_STRAP_SEL_IN,
  input  wire        REG_WR_IN,
  input  wire        REG_RD_IN,
  input  wire [4:0]  REG_ADDR_IN,
  input  wire [15:0] REG_WDATA_IN,
  input  wire [15:0] PARTNER_ABIL_IN,
  input  wire        PARTNER_NEG_IN,
  input  wire        PARALLEL_100_IN,
  input  wire        PARTNER_XOVER_AUTO_IN,
  input  wire        PAIR_SWAP_NEEDED_IN,
  input  wire        TX_EN_IN,
  input  wire [3:0]  TXD_IN,
  output reg  [15:0] REG_RDATA_OUT,
  output reg         REG_RVALID_OUT,
  output reg  [4:0]  MGMT_ADDR_OUT,
  output reg         POWER_DOWN_OUT,
  output reg         INT_RESET_OUT,
  output reg         NEG_ENABLE_OUT,
  output reg         SPEED_100_OUT,
  output reg         FULL_DUPLEX_OUT,
  output reg         CROSSOVER_OUT,
  output reg         MAC_OUT_EN_OUT,
  output reg         TX_EN_GATED_OUT,
  output reg  [3:0]  TXD_GATED_OUT,
  output reg         LINE_DATA_EN_OUT
);

  // ----------------------------------------------------------------------
  // strap synchronisers and one-shot capture
  // ----------------------------------------------------------------------
  localparam STRAP_COUNT = 10;                                // pins behind the synchroniser
  wire [STRAP_COUNT-1:0] strap_sync_w;
  reg  [1:0] rel_q;
  reg        captured_q;
  reg        neg_strap_q;
  reg  [1:0] abil_strap_q;
  reg        xover_strap_q;
  reg        sel_low_q;
  wire [9:0] strap_raw = {SOFT_STRAP_SEL_IN, XOVER_EN_STRAP_IN, ADDR_STRAP_IN,
                          NEG_EN_STRAP_IN, ABIL_HI_STRAP_IN, ABIL_LO_STRAP_IN};

  // two-flop synchroniser per strap pin, first stage read only by the second
  genvar g;
  generate
    for (g = 0; g < STRAP_COUNT; g = g + 1) begin : strap_sync
      reg meta_q;
      reg sync_q;
      always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= strap_raw[g];
          sync_q <= meta_q;
        end
      end
      assign strap_sync_w[g] = sync_q;
    end
  endgenerate

  // release delay, capture waits until the synchroniser holds post-reset levels
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN)
      rel_q <= 2'b00;
    else
      rel_q <= {rel_q[0], 1'b1};
  end

  // capture once, after the synchronised value has settled past reset
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      captured_q    <= 1'b0;
      neg_strap_q   <= 1'b1;
      abil_strap_q  <= 2'b11;
      xover_strap_q <= 1'b1;
      MGMT_ADDR_OUT <= `RESET_PHY_ADDR;
      sel_low_q     <= 1'b0;
    end else if (rel_q[1] && !captured_q) begin
      captured_q    <= 1'b1;
      abil_strap_q  <= strap_sync_w[`STRAP_ABIL_HI:`STRAP_ABIL_LO];
      neg_strap_q   <= strap_sync_w[`STRAP_NEG_EN];
      MGMT_ADDR_OUT <= strap_sync_w[`STRAP_ADDR_HI:`STRAP_ADDR_LO];
      xover_strap_q <= strap_sync_w[`STRAP_XOVER_EN];
      sel_low_q     <= ~strap_sync_w[`STRAP_SOFT_SEL];
    end
  end

  // ----------------------------------------------------------------------
  // advertisement decode shared by reset load and re-latch
  // ----------------------------------------------------------------------
  function [3:0] adv_bits;                                    // {100F,100H,10F,10H}
    input       neg;
    input [1:0] ab;
    begin
      // forced mode advertises only the forced ability
      if (!neg)
        adv_bits = {ab == 2'b11, ab == 2'b10, ab == 2'b01, ab == 2'b00};
      else case (ab)
        2'b00:   adv_bits = 4'b0011;
        2'b01:   adv_bits = 4'b1100;
        2'b10:   adv_bits = 4'b0101;
        default: adv_bits = 4'b1111;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // registers and soft strap sequence
  // ----------------------------------------------------------------------
  // register images
  reg  [15:0] basic_q;
  reg  [15:0] adv_q;
  reg  [15:0] ss1_q;
  reg  [15:0] ss2_q;
  reg  [15:0] ss3_q;
  reg  [15:0] xcvr_q;
  reg  [15:0] rstc_q;
  // effective strap values after hardware or soft strap load
  reg         eff_neg_q;
  reg  [1:0]  eff_abil_q;
  reg         eff_xover_q;
  reg         held_q;
  reg         init_q;
  reg  [3:0]  pulse_cnt_q;
  // decode of release and soft reset requests
  wire        wr_ss1 = REG_WR_IN && (REG_ADDR_IN == `ADDR_SOFT_STRAP_ONE);
  wire        release_w = held_q && wr_ss1 && REG_WDATA_IN[`BIT_SS1_CONFIG_DONE];
  wire        soft_rst_w = REG_WR_IN && (REG_ADDR_IN == `ADDR_SOFT_RESET_CTRL) &&
                           (REG_WDATA_IN[`BIT_RST_SOFT_RESET] ||
                            REG_WDATA_IN[`BIT_RST_SOFT_RESTART]);
  wire [3:0]  ss_adv = adv_bits(REG_WDATA_IN[`BIT_SS1_NEG_EN],
                                REG_WDATA_IN[`BIT_SS1_ABIL_HI:`BIT_SS1_ABIL_LO]);

  // register writes, power-down hold and reset-time loading
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      basic_q     <= `RESET_WORD_ZERO;
      adv_q       <= `RESET_ADV_SELECTOR;
      ss1_q       <= `RESET_WORD_ZERO;
      ss2_q       <= `RESET_WORD_ZERO;
      ss3_q       <= `RESET_WORD_ZERO;
      xcvr_q      <= `RESET_WORD_ZERO;
      rstc_q      <= `RESET_WORD_ZERO;
      eff_neg_q   <= 1'b1;
      eff_abil_q  <= 2'b11;
      eff_xover_q <= 1'b1;
      held_q      <= 1'b0;
      init_q      <= 1'b0;
      pulse_cnt_q <= 4'h0;
    end else begin
      rstc_q <= `RESET_WORD_ZERO;                             // self-clearing bits
      // internal reset pulse counts down to zero
      if (pulse_cnt_q != 4'h0)
        pulse_cnt_q <= pulse_cnt_q - 4'h1;
      if (captured_q && !init_q) begin
        // load strap values once after hardware reset
        init_q      <= 1'b1;
        held_q      <= sel_low_q;
        eff_neg_q   <= neg_strap_q;
        eff_abil_q  <= abil_strap_q;
        eff_xover_q <= xover_strap_q;
        adv_q[`BIT_ADV_100_FULL:`BIT_ADV_10_HALF] <=
          adv_bits(neg_strap_q, abil_strap_q);
        basic_q[`BIT_BASIC_NEG_EN] <= neg_strap_q;
        xcvr_q[`BIT_XCVR_XOVER_EN] <= xover_strap_q;
      end else if (release_w) begin
        // config done: latch soft straps, leave power-down, pulse reset
        held_q      <= 1'b0;
        pulse_cnt_q <= `RESET_INT_PULSE_LEN;
        ss1_q       <= REG_WDATA_IN;
        eff_neg_q   <= REG_WDATA_IN[`BIT_SS1_NEG_EN];
        eff_abil_q  <= REG_WDATA_IN[`BIT_SS1_ABIL_HI:`BIT_SS1_ABIL_LO];
        eff_xover_q <= REG_WDATA_IN[`BIT_SS1_XOVER_EN];
        adv_q[`BIT_ADV_100_FULL:`BIT_ADV_10_HALF] <= ss_adv;
        basic_q[`BIT_BASIC_NEG_EN] <= REG_WDATA_IN[`BIT_SS1_NEG_EN];
        xcvr_q[`BIT_XCVR_XOVER_EN] <= REG_WDATA_IN[`BIT_SS1_XOVER_EN];
      end else if (soft_rst_w) begin
        // soft reset restores latched defaults, keeps soft straps
        pulse_cnt_q <= `RESET_INT_PULSE_LEN;
        basic_q     <= `RESET_WORD_ZERO;
        basic_q[`BIT_BASIC_NEG_EN] <= eff_neg_q;
        adv_q[`BIT_ADV_100_FULL:`BIT_ADV_10_HALF] <= adv_bits(eff_neg_q, eff_abil_q);
        xcvr_q      <= `RESET_WORD_ZERO;
        xcvr_q[`BIT_XCVR_XOVER_EN] <= eff_xover_q;
      end else if (REG_WR_IN) begin
        // register writes work in isolate and in strap hold alike
        case (REG_ADDR_IN)
          `ADDR_BASIC_CTRL:       basic_q <= REG_WDATA_IN;
          `ADDR_ADVERTISE:        adv_q   <= REG_WDATA_IN;
          `ADDR_SOFT_STRAP_ONE:   ss1_q   <= REG_WDATA_IN;
          `ADDR_SOFT_STRAP_TWO:   ss2_q   <= REG_WDATA_IN;
          `ADDR_SOFT_STRAP_THREE: ss3_q   <= REG_WDATA_IN;
          `ADDR_XCVR_CTRL:        xcvr_q  <= REG_WDATA_IN;
          default:                rstc_q  <= `RESET_WORD_ZERO;
        endcase
      end
    end
  end

  // read answer, one cycle after the strobe
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      REG_RDATA_OUT  <= `RESET_WORD_ZERO;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= REG_RD_IN;
      if (REG_RD_IN) begin
        case (REG_ADDR_IN)
          `ADDR_BASIC_CTRL:       REG_RDATA_OUT <= basic_q;
          `ADDR_ADVERTISE:        REG_RDATA_OUT <= adv_q;
          `ADDR_SOFT_STRAP_ONE:   REG_RDATA_OUT <= ss1_q;
          `ADDR_SOFT_STRAP_TWO:   REG_RDATA_OUT <= ss2_q;
          `ADDR_SOFT_STRAP_THREE: REG_RDATA_OUT <= ss3_q;
          `ADDR_XCVR_CTRL:        REG_RDATA_OUT <= xcvr_q;
          `ADDR_SOFT_RESET_CTRL:  REG_RDATA_OUT <= rstc_q;
          default:                REG_RDATA_OUT <= `RESET_WORD_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // speed and duplex resolution
  // ----------------------------------------------------------------------
  wire        neg_on  = basic_q[`BIT_BASIC_NEG_EN];
  // abilities advertised by both sides
  wire [3:0]  common  = adv_q[`BIT_ADV_100_FULL:`BIT_ADV_10_HALF] &
                        PARTNER_ABIL_IN[`BIT_ADV_100_FULL:`BIT_ADV_10_HALF];
  reg         spd_d;
  reg         dup_d;

  // forced, negotiated or parallel-detected mode
  always @* begin
    spd_d = 1'b0;
    dup_d = 1'b0;
    if (!neg_on) begin
      spd_d = eff_abil_q[1];
      dup_d = eff_abil_q[0];
    end else if (!PARTNER_NEG_IN) begin
      spd_d = PARALLEL_100_IN;
      dup_d = 1'b0;
    end else if (common[3]) begin
      spd_d = 1'b1;
      dup_d = 1'b1;
    end else if (common[2]) begin
      spd_d = 1'b1;
    end else if (common[1]) begin
      dup_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // crossover arbitration
  // ----------------------------------------------------------------------
  reg [LFSR_WIDTH-1:0] lfsr_q;
  reg                  xo_q;
  // automatic and forced crossover from transceiver control
  wire auto_on  = xcvr_q[`BIT_XCVR_XOVER_EN];
  wire force_on = xcvr_q[`BIT_XCVR_XOVER_FORCE];

  // random bit and crossover state, independent of speed forcing
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      lfsr_q <= {{(LFSR_WIDTH-1){1'b0}}, 1'b1};
      xo_q   <= 1'b0;
    end else begin
      lfsr_q <= {lfsr_q[LFSR_WIDTH-2:0], lfsr_q[LFSR_WIDTH-1] ^ lfsr_q[LFSR_WIDTH-3]};
      if (auto_on && PAIR_SWAP_NEEDED_IN) begin
        if (PARTNER_XOVER_AUTO_IN)
          xo_q <= xo_q ^ lfsr_q[0];
        else
          // no arbiter on the far side: swap on every failed pairing
          xo_q <= ~xo_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  wire iso   = basic_q[`BIT_BASIC_ISOLATE];
  wire quiet = iso | held_q;                                  // isolated or held powered down

  // power and reset status, every top output from a flip-flop
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      POWER_DOWN_OUT   <= 1'b0;
      INT_RESET_OUT    <= 1'b0;
    end else begin
      POWER_DOWN_OUT   <= held_q || (captured_q && !init_q && sel_low_q);
      INT_RESET_OUT    <= pulse_cnt_q != 4'h0;
    end
  end

  // resolved link mode and crossover
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      NEG_ENABLE_OUT   <= 1'b0;
      SPEED_100_OUT    <= 1'b0;
      FULL_DUPLEX_OUT  <= 1'b0;
      CROSSOVER_OUT    <= 1'b0;
    end else begin
      NEG_ENABLE_OUT   <= neg_on;
      SPEED_100_OUT    <= spd_d;
      FULL_DUPLEX_OUT  <= dup_d;
      CROSSOVER_OUT    <= force_on | (auto_on & xo_q);
    end
  end

  // MAC side gating, quiet while isolated or held in power-down
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      MAC_OUT_EN_OUT   <= 1'b0;
      TX_EN_GATED_OUT  <= 1'b0;
      TXD_GATED_OUT    <= 4'h0;
      LINE_DATA_EN_OUT <= 1'b0;
    end else begin
      MAC_OUT_EN_OUT   <= ~quiet;
      TX_EN_GATED_OUT  <= TX_EN_IN & ~quiet;
      TXD_GATED_OUT    <= quiet ? 4'h0 : TXD_IN;
      LINE_DATA_EN_OUT <= ~quiet;
    end
  end

endmodule

// ### dv/strap_link_config_asserts.sv
/* concurrent checks on the strap and link configuration ports.
   assumes the bind below attaches it to every design instance. */
`timescale 1ns/10ps
module strap_link_config_asserts (
  input wire        CLOCK_IN,
  input wire        RESET_N_IN,
  input wire        REG_WR_IN,
  input wire        REG_RD_IN,
  input wire [4:0]  REG_ADDR_IN,
  input wire [15:0] REG_WDATA_IN,
  input wire        PARTNER_NEG_IN,
  input wire [15:0] REG_RDATA_OUT,
  input wire        REG_RVALID_OUT,
  input wire [4:0]  MGMT_ADDR_OUT,
  input wire        POWER_DOWN_OUT,
  input wire        INT_RESET_OUT,
  input wire        NEG_ENABLE_OUT,
  input wire        FULL_DUPLEX_OUT,
  input wire        MAC_OUT_EN_OUT,
  input wire        TX_EN_GATED_OUT,
  input wire [3:0]  TXD_GATED_OUT,
  input wire        LINE_DATA_EN_OUT
);
  reg [2:0] since_q;
  // cycles since reset release, saturating at seven
  always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN)
      since_q <= 3'h0;
    else if (since_q != 3'h7)
      since_q <= since_q + 3'h1;
  end
  default clocking dc @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);
  a_read_answered: assert property (REG_RD_IN |=> REG_RVALID_OUT)
    else $error("read not answered next cycle");
  a_answer_has_cause: assert property (REG_RVALID_OUT |-> $past(REG_RD_IN))
    else $error("read answer without request");
  a_rdata_holds: assert property (!REG_RVALID_OUT |-> $stable(REG_RDATA_OUT))
    else $error("read data moved without answer");
  a_isolate_tx_gate: assert property (!MAC_OUT_EN_OUT |->
    (!TX_EN_GATED_OUT && TXD_GATED_OUT == 4'h0))
    else $error("transmit passed while isolated");
  a_isolate_line: assert property (!MAC_OUT_EN_OUT |-> !LINE_DATA_EN_OUT)
    else $error("line data enabled while isolated");
  a_pulse_length: assert property ($rose(INT_RESET_OUT) |->
    INT_RESET_OUT[*4] ##1 !INT_RESET_OUT)
    else $error("internal reset pulse not four cycles");
  a_release_wakes: assert property ((POWER_DOWN_OUT && REG_WR_IN &&
    REG_ADDR_IN == 5'h09 && REG_WDATA_IN[15]) |-> ##[1:2] (!POWER_DOWN_OUT && INT_RESET_OUT))
    else $error("config done did not leave power-down");
  a_addr_held: assert property (since_q == 3'h7 |-> $stable(MGMT_ADDR_OUT))
    else $error("latched address changed");
  a_parallel_half: assert property ((NEG_ENABLE_OUT && !PARTNER_NEG_IN)[*4] |->
    !FULL_DUPLEX_OUT)
    else $error("parallel detect gave full duplex");
endmodule
bind strap_link_config strap_link_config_asserts chk_u (
  .CLOCK_IN(CLOCK_IN), .RESET_N_IN(RESET_N_IN), .REG_WR_IN(REG_WR_IN),
  .REG_RD_IN(REG_RD_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
  .PARTNER_NEG_IN(PARTNER_NEG_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .REG_RVALID_OUT(REG_RVALID_OUT), .MGMT_ADDR_OUT(MGMT_ADDR_OUT),
  .POWER_DOWN_OUT(POWER_DOWN_OUT), .INT_RESET_OUT(INT_RESET_OUT),
  .NEG_ENABLE_OUT(NEG_ENABLE_OUT), .FULL_DUPLEX_OUT(FULL_DUPLEX_OUT),
  .MAC_OUT_EN_OUT(MAC_OUT_EN_OUT), .TX_EN_GATED_OUT(TX_EN_GATED_OUT),
  .TXD_GATED_OUT(TXD_GATED_OUT), .LINE_DATA_EN_OUT(LINE_DATA_EN_OUT));

// ### dv/mgmt_host_model.sv
/* station management host: one-cycle register strobes on the falling edge.
   assumes the design registers read answers on the taking edge, sampled half a cycle later. */
`timescale 1ns/10ps
module mgmt_host_model (
  input  wire        clk_in,
  input  wire [15:0] rdata_in,
  input  wire        rvalid_in,
  output reg         wr_out,
  output reg         rd_out,
  output reg  [4:0]  addr_out,
  output reg  [15:0] wdata_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 5'h1E;
    wdata_out = 16'hA5A5;
  end
  // strobe held over one rising edge, released lines show inverse
  task write_reg(input [4:0] a, input [15:0] d);
    begin
      @(negedge clk_in);
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(negedge clk_in);
      wr_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
    end
  endtask
  // read strobe, then answer sampled in its one valid cycle
  task read_reg(input [4:0] a, output [15:0] d, output ok);
    begin
      @(negedge clk_in);
      addr_out = a;
      rd_out = 1'b1;
      @(negedge clk_in);
      d = rdata_in;
      ok = rvalid_in;
      rd_out = 1'b0;
      addr_out = ~a;
    end
  endtask
endmodule

// ### dv/test_strap_link_config.sv
/* self-checking bench for strap_link_config.
   assumes mgmt_host_model as register host and the bound checker. */
`timescale 1ns/10ps
module test_strap_link_config;
  reg CLOCK_IN, RESET_N_IN, NEG_EN, AB_HI, AB_LO, XO_EN, SEL;
  reg PNEG, P100, PXA, SWAP, TXEN;
  reg [4:0] ADDR_S;
  reg [3:0] TXD;
  reg [15:0] PABIL, rd;
  reg ok, c0;
  wire WR, RDS, RVALID, PD, INTR, NEGO, SPD, FDX, XOV, MACEN, TXG, LDE;
  wire [4:0] RADDR, MADDR;
  wire [15:0] WDATA, RDATA;
  wire [3:0] TXDG;
  integer errors, checks, cycles, i;
  strap_link_config dut_u (.CLOCK_IN(CLOCK_IN), .RESET_N_IN(RESET_N_IN),
    .NEG_EN_STRAP_IN(NEG_EN), .ABIL_HI_STRAP_IN(AB_HI), .ABIL_LO_STRAP_IN(AB_LO),
    .XOVER_EN_STRAP_IN(XO_EN), .ADDR_STRAP_IN(ADDR_S), .SOFT_STRAP_SEL_IN(SEL),
    .REG_WR_IN(WR), .REG_RD_IN(RDS), .REG_ADDR_IN(RADDR), .REG_WDATA_IN(WDATA),
    .PARTNER_ABIL_IN(PABIL), .PARTNER_NEG_IN(PNEG), .PARALLEL_100_IN(P100),
    .PARTNER_XOVER_AUTO_IN(PXA), .PAIR_SWAP_NEEDED_IN(SWAP), .TX_EN_IN(TXEN),
    .TXD_IN(TXD), .REG_RDATA_OUT(RDATA), .REG_RVALID_OUT(RVALID), .MGMT_ADDR_OUT(MADDR),
    .POWER_DOWN_OUT(PD), .INT_RESET_OUT(INTR), .NEG_ENABLE_OUT(NEGO), .SPEED_100_OUT(SPD),
    .FULL_DUPLEX_OUT(FDX), .CROSSOVER_OUT(XOV), .MAC_OUT_EN_OUT(MACEN),
    .TX_EN_GATED_OUT(TXG), .TXD_GATED_OUT(TXDG), .LINE_DATA_EN_OUT(LDE));
  mgmt_host_model host_u (.clk_in(CLOCK_IN), .rdata_in(RDATA), .rvalid_in(RVALID),
    .wr_out(WR), .rd_out(RDS), .addr_out(RADDR), .wdata_out(WDATA));
  initial begin
    CLOCK_IN = 1'b0;
    forever #5 CLOCK_IN = ~CLOCK_IN;
  end
  // hang guard
  always @(posedge CLOCK_IN) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      complete_run;
    end
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // straps set, reset held five cycles, first access six edges later
  task hw_reset(input [2:0] m, input xo, input [4:0] ad, input sel);
    begin
      @(negedge CLOCK_IN);
      {NEG_EN, AB_HI, AB_LO} = m;
      XO_EN = xo;
      ADDR_S = ad;
      SEL = sel;
      RESET_N_IN = 1'b0;
      repeat (5) @(negedge CLOCK_IN);
      check(MADDR, 16'h0001);
      RESET_N_IN = 1'b1;
      repeat (6) @(negedge CLOCK_IN);
    end
  endtask
  function [15:0] adv_exp(input n, input [1:0] ab);
    reg [3:0] m;
    begin
      if (!n) m = 4'b0001 << ab;
      else if (ab == 2'd0) m = 4'b0011;
      else if (ab == 2'd1) m = 4'b1100;
      else if (ab == 2'd2) m = 4'b0101;
      else m = 4'b1111;
      adv_exp = {7'h00, m, 5'h01};
    end
  endfunction
  initial begin
    {RESET_N_IN, NEG_EN, AB_HI, AB_LO, XO_EN, SEL, PNEG, P100, PXA, SWAP, TXEN} = 11'h001;
    {ADDR_S, TXD, PABIL} = 25'h000_0000;
    errors = 0;
    checks = 0;
    cycles = 0;
    // every strap mode, distinct address each time
    for (i = 0; i < 8; i = i + 1) begin
      hw_reset(i[2:0], 1'b1, i[4:0] * 5'h04 + 5'h03, 1'b1);
      host_u.read_reg(5'h04, rd, ok);
      check(rd, adv_exp(i[2], i[1:0]));
      check(ok, 1'b1);
      check(MADDR, i[4:0] * 5'h04 + 5'h03);
      check(NEGO, i[2]);
      if (!i[2]) check({SPD, FDX}, i[1:0]);
      ADDR_S = ~ADDR_S;
      {NEG_EN, AB_HI, AB_LO} = ~i[2:0];
      repeat (4) @(negedge CLOCK_IN);
      check(MADDR, i[4:0] * 5'h04 + 5'h03);
    end
    $display("test strap modes done");
    // best common mode, then parallel detect
    PNEG = 1'b1;
    for (i = 1; i < 16; i = i + 1) begin
      PABIL = {7'h00, i[3:0], 5'h01};
      repeat (8) @(negedge CLOCK_IN);
      check({SPD, FDX}, {i[3] | i[2], i[3] | (~i[2] & i[1])});
    end
    PNEG = 1'b0;
    for (i = 0; i < 2; i = i + 1) begin
      P100 = i[0];
      repeat (8) @(negedge CLOCK_IN);
      check({SPD, FDX}, {i[0], 1'b0});
    end
    $display("test resolution done");
    // isolation and release of isolation
    {TXEN, TXD} = 5'h1A;
    host_u.write_reg(5'h00, 16'h1400);
    repeat (2) @(negedge CLOCK_IN);
    check({MACEN, TXG, TXDG, LDE}, 16'h0000);
    host_u.read_reg(5'h04, rd, ok);
    check({ok, rd}, {1'b1, adv_exp(1'b1, 2'd3)});
    host_u.read_reg(5'h1E, rd, ok);
    check(rd, 16'h0000);
    host_u.write_reg(5'h00, 16'h1000);
    repeat (2) @(negedge CLOCK_IN);
    check({MACEN, TXG, TXDG, LDE}, 16'h0075);
    $display("test isolation done");
    // crossover: strap off, forced swap, automatic in forced 100
    hw_reset(3'b000, 1'b0, 5'h01, 1'b1);
    host_u.read_reg(5'h19, rd, ok);
    check(rd[15], 1'b0);
    host_u.write_reg(5'h19, 16'h4000);
    repeat (2) @(negedge CLOCK_IN);
    check(XOV, 1'b1);
    host_u.write_reg(5'h19, 16'h0000);
    repeat (2) @(negedge CLOCK_IN);
    check(XOV, 1'b0);
    hw_reset(3'b011, 1'b1, 5'h01, 1'b1);
    host_u.read_reg(5'h19, rd, ok);
    check(rd[15], 1'b1);
    SWAP = 1'b1;
    c0 = XOV;
    for (i = 0; i < 3000 && XOV === c0; i = i + 1) @(negedge CLOCK_IN);
    check(XOV, !c0);
    PXA = 1'b1;
    c0 = XOV;
    for (i = 0; i < 3000 && XOV === c0; i = i + 1) @(negedge CLOCK_IN);
    check(XOV, !c0);
    SWAP = 1'b0;
    $display("test crossover done");
    // soft strap mode: hold, program, release, soft reset
    hw_reset(3'b100, 1'b1, 5'h01, 1'b0);
    check({PD, MACEN}, 16'h0002);
    host_u.write_reg(5'h0A, 16'h1234);
    host_u.write_reg(5'h0B, 16'h5678);
    host_u.read_reg(5'h0A, rd, ok);
    check(rd, 16'h1234);
    host_u.write_reg(5'h09, 16'h1C00);
    host_u.write_reg(5'h09, 16'h9C00);
    repeat (2) @(negedge CLOCK_IN);
    check({PD, INTR}, 16'h0001);
    repeat (10) @(negedge CLOCK_IN);
    check({NEGO, SPD, FDX}, 16'h0003);
    host_u.read_reg(5'h19, rd, ok);
    check(rd[15], 1'b0);
    host_u.write_reg(5'h1F, 16'h8000);
    repeat (10) @(negedge CLOCK_IN);
    check({NEGO, SPD, FDX}, 16'h0003);
    host_u.read_reg(5'h0B, rd, ok);
    check(rd, 16'h5678);
    $display("test soft straps done");
    complete_run;
  end
endmodule
